// ==== inc/adcfmt_defs.svh ====
// offsets, field positions, reset values and counts of the converter control
`ifndef ADCFMT_DEFS_SVH
`define ADCFMT_DEFS_SVH
// ==========================================================
// register byte offsets
`define ADCF_A_CTRL 8'h00
`define ADCF_A_FMT 8'h04
`define ADCF_A_MODE 8'h08
`define ADCF_A_STAT 8'h0c
`define ADCF_A_IST 8'h10
`define ADCF_A_IMSK 8'h14
// ==========================================================
// field positions
`define ADCF_B_SER 0
`define ADCF_B_PWR_LO 1
`define ADCF_B_DCOINV 3
`define ADCF_B_FMT_LO 2
`define ADCF_B_MF_LO 5
// ==========================================================
// power mode and mode pin function codes
`define ADCF_PM_RUN 2'h0
`define ADCF_PM_DOWN 2'h1
`define ADCF_PM_STBY 2'h2
`define ADCF_MF_OFF 2'h0
`define ADCF_MF_PD 2'h1
`define ADCF_MF_SB 2'h2
`define ADCF_MF_OEB 2'h3
// ==========================================================
// output format codes and data limits
`define ADCF_FMT_OB 2'h0
`define ADCF_FMT_TC 2'h1
`define ADCF_FMT_GRAY 2'h2
`define ADCF_CODE_MAX 14'h3fff
`define ADCF_CODE_MIN 14'h0000
`define ADCF_IN_MAX 16'sh3fff
// ==========================================================
// reset values and counts
`define ADCF_RST_ZERO 32'h0000_0000
`define ADCF_NIRQ 3
`define ADCF_STRAP_WAIT 2'h3
`endif

// ==== inc/adcfmt_pkg.sv ====
// types shared by the converter control block
package adcfmt_pkg;
    // power sequencing states
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_STBY,
        PWR_DOWN,
        PWR_WAKE
    } adcf_pwr_t;
    // one pipeline word: overrange flag above 14 data bits
    typedef logic [14:0] adcf_word_t;
endpackage : adcfmt_pkg

// ==== verilog/adcfmt_top.sv ====
// converter control: clock divide, power, output format, ahb registers
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "adcfmt_defs.svh"

// Function
// - divide sample clock by one, two, four
// - strap pin high powers device down without serial configuration
// - pin or mode pin low wakes device
// - serial command or mode pin powers down
// - powered down means data drivers released
// - serial standby keeps reference, quick wake
// - strap picks offset binary or twos complement
// - serial mode adds gray code format
// - mode pin function field bits six five
// - output enable bar gates data, dco
// - result appears eight conversion cycles later
// - outputs update after conversion clock edge
// - data clock out, polarity selectable
// - clamp out of range, flag overrange
// - fourteen data bits plus overrange flag
module adcfmt_top #(
    parameter int LAT = 8,
    parameter int WAKE_DOWN_CYC = 16,
    parameter int WAKE_STBY_CYC = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic signed [15:0] core_sample,
    input wire logic power_down_pin,
    input wire logic mode_pin,
    input wire logic serial_clock_format_strap,
    output logic [13:0] data_o,
    output logic overrange_o,
    output logic data_oe,
    output logic data_clock_out,
    output logic data_clock_oe,
    output logic irq
);
    // ==========================================================
    // pin synchronisers
    logic [2:0] pin_raw; // asynchronous pins
    logic [2:0] s1_r; // first stage, read by s2 only
    logic [2:0] s2_r;
    logic [2:0] s3_r;
    logic [2:0] pin_st_r; // accepted pin levels
    assign pin_raw = {serial_clock_format_strap, mode_pin,
                      power_down_pin};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            // change counts once stages two and three agree
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                    s3_r[gi] <= 1'b0;
                    pin_st_r[gi] <= 1'b0;
                end
                else
                begin
                    s1_r[gi] <= pin_raw[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi])
                        pin_st_r[gi] <= s3_r[gi];
                end
            end
        end
    endgenerate
    logic pd_pin; // accepted power-down strap level
    logic mode_lv; // accepted mode pin level
    assign pd_pin = pin_st_r[0];
    assign mode_lv = pin_st_r[1];

    // ==========================================================
    // format strap, caught once the synchroniser has settled
    logic [1:0] strap_cnt_r;
    logic fmt_strap_r; // 1: twos complement
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            strap_cnt_r <= 2'h0;
            fmt_strap_r <= 1'b0;
        end
        else if (strap_cnt_r != `ADCF_STRAP_WAIT)
        begin
            // count agreeing cycles only, so the level has reached s3
            if (s2_r[2] == s3_r[2])
                strap_cnt_r <= strap_cnt_r + 2'h1;
            fmt_strap_r <= s3_r[2]; // late pins cannot change it
        end
    end

    // ==========================================================
    // software registers
    logic ser_r; // serial configuration in use
    logic [1:0] pmode_r; // software power mode
    logic dco_inv_r; // data clock polarity
    logic [1:0] div_r; // 0:/1 1:/2 2:/4
    logic [1:0] fmt_r; // serial output format
    logic [1:0] mfun_r; // mode pin function
    logic [2:0] ist_r; // sticky events
    logic [2:0] imsk_r; // event mask
    logic a_wr_r; // pending write data phase
    logic [7:0] a_addr_r; // its address
    logic ap_take;
    logic wr_go;
    assign ap_take = hsel && htrans[1] && hready;
    assign wr_go = a_wr_r;
    assign hreadyout = 1'b1; // zero wait, always OKAY
    assign hresp = 1'b0;

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            a_wr_r <= 1'b0;
            a_addr_r <= 8'h00;
        end
        else
        begin
            a_wr_r <= ap_take && hwrite;
            a_addr_r <= haddr;
        end
    end

    // control registers written in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ser_r <= 1'b0;
            pmode_r <= `ADCF_PM_RUN;
            dco_inv_r <= 1'b0;
            div_r <= 2'h0;
            fmt_r <= `ADCF_FMT_OB;
            mfun_r <= `ADCF_MF_OFF;
            imsk_r <= 3'h0;
        end
        else if (wr_go)
        begin
            case (a_addr_r)
                `ADCF_A_CTRL:
                begin
                    ser_r <= hwdata[`ADCF_B_SER];
                    pmode_r <= hwdata[`ADCF_B_PWR_LO +: 2];
                    dco_inv_r <= hwdata[`ADCF_B_DCOINV];
                end
                `ADCF_A_FMT:
                begin
                    div_r <= (hwdata[1:0] == 2'h3) ? 2'h2 : hwdata[1:0];
                    fmt_r <= hwdata[`ADCF_B_FMT_LO +: 2];
                end
                `ADCF_A_MODE:
                    mfun_r <= hwdata[`ADCF_B_MF_LO +: 2];
                `ADCF_A_IMSK:
                    imsk_r <= hwdata[2:0];
                default:
                    ; // unmapped or read-only: ignored
            endcase
        end
    end

    // ==========================================================
    // power sequencing
    adcfmt_pkg::adcf_pwr_t pwr_r;
    logic [15:0] wake_r; // wake countdown
    logic pd_req; // power-down wanted
    logic sb_req; // standby wanted
    logic run;
    // strap pin alone without serial; command or pin with it
    assign pd_req = ser_r ? ((pmode_r == `ADCF_PM_DOWN)
                    || (mfun_r == `ADCF_MF_PD && mode_lv))
                    : pd_pin;
    // standby is only reachable under serial configuration
    assign sb_req = ser_r && !pd_req &&
                    ((pmode_r == `ADCF_PM_STBY)
                    || (mfun_r == `ADCF_MF_SB && mode_lv));
    assign run = (pwr_r == adcfmt_pkg::PWR_RUN);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pwr_r <= adcfmt_pkg::PWR_RUN;
            wake_r <= 16'h0;
        end
        else
        begin
            case (pwr_r)
                adcfmt_pkg::PWR_RUN:
                    if (pd_req)
                        pwr_r <= adcfmt_pkg::PWR_DOWN;
                    else if (sb_req)
                        pwr_r <= adcfmt_pkg::PWR_STBY;
                adcfmt_pkg::PWR_DOWN:
                    if (!pd_req)
                    begin
                        pwr_r <= sb_req ? adcfmt_pkg::PWR_STBY
                                        : adcfmt_pkg::PWR_WAKE;
                        wake_r <= 16'(WAKE_DOWN_CYC - 1);
                    end
                adcfmt_pkg::PWR_STBY:
                    if (pd_req)
                        pwr_r <= adcfmt_pkg::PWR_DOWN;
                    else if (!sb_req)
                    begin
                        // reference kept up: shorter wake
                        pwr_r <= adcfmt_pkg::PWR_WAKE;
                        wake_r <= 16'(WAKE_STBY_CYC - 1);
                    end
                adcfmt_pkg::PWR_WAKE:
                    if (pd_req)
                        pwr_r <= adcfmt_pkg::PWR_DOWN;
                    else if (sb_req)
                        pwr_r <= adcfmt_pkg::PWR_STBY;
                    else if (wake_r == 16'h0)
                        pwr_r <= adcfmt_pkg::PWR_RUN;
                    else
                        wake_r <= wake_r - 16'h1;
                default:
                    pwr_r <= adcfmt_pkg::PWR_DOWN;
            endcase
        end
    end

    // ==========================================================
    // conversion clock divider
    logic [1:0] dcnt_r;
    logic [1:0] dlast; // last count of a period
    logic tick; // one conversion clock edge
    // a source above rating must be divided down by software
    assign dlast = (div_r == 2'h0) ? 2'h0 :
                   (div_r == 2'h1) ? 2'h1 : 2'h3;
    assign tick = run && (dcnt_r == dlast);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            dcnt_r <= 2'h0;
        else if (!run || dcnt_r >= dlast)
            dcnt_r <= 2'h0;
        else
            dcnt_r <= dcnt_r + 2'h1;
    end

    // ==========================================================
    // clamp and pipeline
    adcfmt_pkg::adcf_word_t clamp_w; // clamped sample, flag
    adcfmt_pkg::adcf_word_t pipe_r [LAT];
    always_comb
    begin
        // out of range sticks to the end codes with the flag
        if (core_sample < 16'sh0)
            clamp_w = {1'b1, `ADCF_CODE_MIN};
        else if (core_sample > `ADCF_IN_MAX)
            clamp_w = {1'b1, `ADCF_CODE_MAX};
        else
            clamp_w = {1'b0, core_sample[13:0]};
    end
    generate
        for (gi = 0; gi < LAT; gi++)
        begin : g_pipe
            // stage gi, advanced on conversion edges only
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    pipe_r[gi] <= 15'h0;
                else if (tick)
                    pipe_r[gi] <= (gi == 0) ? clamp_w
                                            : pipe_r[(gi == 0) ? 0 : gi - 1];
            end
        end
    endgenerate

    // ==========================================================
    // output format and drivers
    logic [1:0] fmt_eff; // format in force
    logic [13:0] ob; // offset binary of last stage
    logic [13:0] fmt_w;
    assign fmt_eff = ser_r ? fmt_r :
                     (fmt_strap_r ? `ADCF_FMT_TC : `ADCF_FMT_OB);
    assign ob = pipe_r[LAT-1][13:0];
    always_comb
    begin
        case (fmt_eff)
            `ADCF_FMT_TC:
                fmt_w = {~ob[13], ob[12:0]};
            `ADCF_FMT_GRAY:
                fmt_w = ob ^ {1'b0, ob[13:1]};
            default:
                fmt_w = ob;
        endcase
    end
    // data registers, changed right after a conversion edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            data_o <= 14'h0;
            overrange_o <= 1'b0;
        end
        else if (tick)
        begin
            data_o <= fmt_w;
            overrange_o <= pipe_r[LAT-1][14];
        end
    end
    logic oeb_off; // mode pin releases the bus
    assign oeb_off = ser_r && (mfun_r == `ADCF_MF_OEB) && mode_lv;
    // enables and data clock; with dco_inv_r clear, dco low while data changes, held high at divide by one
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            data_oe <= 1'b0;
            data_clock_oe <= 1'b0;
            data_clock_out <= 1'b0;
        end
        else
        begin
            data_oe <= run && !oeb_off;
            data_clock_oe <= run && !oeb_off;
            data_clock_out <= (!tick || div_r == 2'h0)
                              ^ dco_inv_r;
        end
    end

    // ==========================================================
    // interrupts: set wins over write-one-to-clear
    logic [2:0] ev; // overrange, powered down, woke up
    logic [2:0] iclr;
    adcfmt_pkg::adcf_pwr_t pwr_d_r;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pwr_d_r <= adcfmt_pkg::PWR_RUN;
        else
            pwr_d_r <= pwr_r;
    end
    assign ev[0] = tick && pipe_r[LAT-1][14];
    assign ev[1] = (pwr_r == adcfmt_pkg::PWR_DOWN)
                   && (pwr_d_r != adcfmt_pkg::PWR_DOWN);
    assign ev[2] = run && (pwr_d_r == adcfmt_pkg::PWR_WAKE);
    assign iclr = (wr_go && a_addr_r == `ADCF_A_IST) ?
                  hwdata[2:0] : 3'h0;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ist_r <= 3'h0;
        else
            ist_r <= (ist_r & ~iclr) | ev;
    end
    assign irq = |(ist_r & imsk_r);

    // ==========================================================
    // read data, registered in the address phase
    logic [31:0] rd_w;
    always_comb
    begin
        rd_w = `ADCF_RST_ZERO;
        case (haddr)
            `ADCF_A_CTRL:
                rd_w[3:0] = {dco_inv_r, pmode_r, ser_r};
            `ADCF_A_FMT:
                rd_w[3:0] = {fmt_r, div_r};
            `ADCF_A_MODE:
                rd_w[6:5] = mfun_r;
            `ADCF_A_STAT:
                rd_w[5:0] = {overrange_o, mode_lv, pd_pin,
                             fmt_strap_r, pwr_r};
            `ADCF_A_IST:
                rd_w[2:0] = ist_r;
            `ADCF_A_IMSK:
                rd_w[2:0] = imsk_r;
            default:
                rd_w = `ADCF_RST_ZERO; // unmapped reads zero
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= `ADCF_RST_ZERO;
        else if (ap_take && !hwrite)
            hrdata <= rd_w;
    end

    // ==========================================================
    // assertions
    div_four_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (tick && div_r == 2'h2 && $stable(div_r))
        |=> (!tick || div_r != 2'h2)[*3])
        else $error("divide by four ticks too soon");
    pin_down_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ser_r && pd_pin) |=> ##[0:1] pwr_r == adcfmt_pkg::PWR_DOWN)
        else $error("strap pin did not power down");
    wake_up_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pwr_r == adcfmt_pkg::PWR_DOWN && !pd_req && !sb_req)
        |=> pwr_r == adcfmt_pkg::PWR_WAKE)
        else $error("release did not start wake");
    sw_down_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ser_r && pmode_r == `ADCF_PM_DOWN) |=> ##[0:1]
        pwr_r == adcfmt_pkg::PWR_DOWN)
        else $error("serial command did not power down");
    off_hiz_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pwr_r == adcfmt_pkg::PWR_DOWN) |=> !data_oe)
        else $error("drivers on while powered down");
    stby_ser_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pwr_r == adcfmt_pkg::PWR_STBY) |-> $past(ser_r))
        else $error("standby without serial configuration");
    oeb_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        oeb_off |=> (!data_oe && !data_clock_oe))
        else $error("oeb high left drivers on");
    upd_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !$stable(data_o) |-> $past(tick))
        else $error("data changed without conversion edge");
    clamp_or_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (tick && ev[0] && fmt_eff == `ADCF_FMT_OB) |=>
        (overrange_o && (data_o == `ADCF_CODE_MAX
        || data_o == `ADCF_CODE_MIN)))
        else $error("overrange not at an end code");
    twos_msb_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (tick && fmt_eff == `ADCF_FMT_TC) |=>
        data_o == {~$past(ob[13]), $past(ob[12:0])})
        else $error("twos complement code wrong");
    run_c: cover property (@(posedge hclk) disable iff (!hresetn)
        tick && ev[0]);
    down_c: cover property (@(posedge hclk) disable iff (!hresetn)
        ev[1] ##[1:100] ev[2]);
    oeb_c: cover property (@(posedge hclk) disable iff (!hresetn)
        run && oeb_off);
    gray_c: cover property (@(posedge hclk) disable iff (!hresetn)
        tick && fmt_eff == `ADCF_FMT_GRAY);
endmodule : adcfmt_top

// ==== sim/adcfmt_capture.sv ====
// capture register model on the far side of the output bus
`timescale 1ns/1ps
module adcfmt_capture (
    input wire logic [13:0] data_o,
    input wire logic overrange_o,
    input wire logic data_oe,
    input wire logic data_clock_out,
    input wire logic data_clock_oe,
    input wire logic inv,
    output logic [14:0] cap_word,
    output int cap_count
);
    // ==========================================================
    // bus wires as the capture logic sees them
    logic [14:0] last_w = 15'h0000; // last word actually driven
    logic [14:0] bus_w; // released bus shows the inverse, no pull
    logic clk_w; // active edge made rising by the polarity input
    initial cap_count = 0;
    // remember the driven word so a release cannot look like data
    always @(data_o or overrange_o or data_oe)
        if (data_oe)
            last_w = {overrange_o, data_o};
    assign bus_w = data_oe ? {overrange_o, data_o} : ~last_w;
    assign clk_w = data_clock_out ^ inv;
    // ==========================================================
    // capture on the active edge of the data clock only
    always @(posedge clk_w)
        if (data_clock_oe)
        begin
            cap_word <= bus_w;
            cap_count <= cap_count + 1;
        end
endmodule : adcfmt_capture

// ==== sim/adcfmt_top_bench.sv ====
// self-checking bench of the converter control block
`timescale 1ns/1ps
`include "adcfmt_defs.svh"
module adcfmt_top_bench;
    // ==========================================================
    // bench signals
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2; // word transfers only
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout, hresp, irq, overrange_o;
    logic data_oe, data_clock_out, data_clock_oe;
    logic signed [15:0] core_sample = 16'sh0000;
    logic power_down_pin = 1'b0;
    logic mode_pin = 1'b0;
    logic strap = 1'b0;
    logic [13:0] data_o;
    logic inv = 1'b0; // capture polarity of the far side
    logic [14:0] cap_word;
    int cap_count;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0; // timeout counter
    int run = 0; // ramp step
    int settle = 0; // cycles since pipeline checks were enabled
    int n_down, n_stby, c0, i;
    bit ramp = 1'b0;
    bit chk_en = 1'b0;
    logic [1:0] exp_fmt = 2'h0;
    logic signed [15:0] hist[$]; // samples as taken, newest first
    logic [31:0] rd;
    // source kept at the rated rate, so any divide ratio is legal
    initial forever #20 hclk = ~hclk;
    // ==========================================================
    // design and far side
    adcfmt_top #(.WAKE_DOWN_CYC(2), .WAKE_STBY_CYC(1)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .core_sample(core_sample),
        .power_down_pin(power_down_pin), .mode_pin(mode_pin),
        .serial_clock_format_strap(strap), .data_o(data_o),
        .overrange_o(overrange_o), .data_oe(data_oe),
        .data_clock_out(data_clock_out),
        .data_clock_oe(data_clock_oe), .irq(irq));
    adcfmt_capture cap_u (
        .data_o(data_o), .overrange_o(overrange_o), .data_oe(data_oe),
        .data_clock_out(data_clock_out), .data_clock_oe(data_clock_oe),
        .inv(inv), .cap_word(cap_word), .cap_count(cap_count));
    // ==========================================================
    // expected output word: clamp, flag, then format
    function automatic logic [14:0] fmt_of(logic signed [15:0] s,
                                           logic [1:0] f);
        logic [13:0] b;
        logic o;
        o = (s < 0) || (s > `ADCF_IN_MAX);
        b = (s < 0) ? `ADCF_CODE_MIN : (o ? `ADCF_CODE_MAX : s[13:0]);
        if (f == `ADCF_FMT_TC)
            b = b ^ 14'h2000;
        else if (f == `ADCF_FMT_GRAY)
            b = b ^ (b >> 1);
        return {o, b};
    endfunction : fmt_of
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
            begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    // ==========================================================
    // bus cycles: address phase, then data phase, both until ready
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
        @(posedge hclk); // written value lands at the last bus edge
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        check(rd, e);
        check(32'(hresp), 32'h0);
    endtask : rdc
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : wait_cyc
    // bounded wait for the drivers to come back, returns the cycles
    task automatic wait_oe(output int n);
        n = 0;
        while (data_oe !== 1'b1 && n < 200)
        begin
            @(posedge hclk);
            n++;
        end
        check(32'(n < 200), 32'h1);
    endtask : wait_oe
    task automatic do_reset(input logic s);
        chk_en = 1'b0;
        hresetn <= 1'b0;
        strap <= s;
        wait_cyc(6);
        hresetn <= 1'b1;
        wait_cyc(6);
    endtask : do_reset
    // ==========================================================
    // sample history, ramp through and past both limits, timeout
    always @(posedge hclk)
    begin
        hist.push_front(core_sample);
        if (hist.size() > 9)
            void'(hist.pop_back());
        if (ramp)
            core_sample <= 16'((run * 1237) % 18000 - 800);
        run++;
        cyc++;
        if (cyc == 6000)
        begin
            errors++;
            stop_test();
        end
    end
    // checked mid-cycle, once the edge's updates have landed
    always @(negedge hclk)
    begin
        if (chk_en && settle > 12 && hist.size() == 9)
            check(32'({overrange_o, data_o}), 32'(fmt_of(hist[8], exp_fmt)));
        settle <= chk_en ? settle + 1 : 0;
    end
    // ==========================================================
    // test sequence
    initial
    begin
        do_reset(1'b0);
        rdc(`ADCF_A_CTRL, `ADCF_RST_ZERO);
        rdc(`ADCF_A_FMT, `ADCF_RST_ZERO);
        rdc(8'h20, 32'h0000_0000);
        ramp = 1'b1;
        chk_en = 1'b1;
        wait_cyc(80);
        chk_en = 1'b0;
        check(32'(data_clock_out), 32'h1);
        $display("test strap format done");
        for (i = 0; i < 3; i++)
        begin
            wr(`ADCF_A_CTRL, 32'h0000_0001);
            wr(`ADCF_A_FMT, 32'(i) << `ADCF_B_FMT_LO);
            exp_fmt = 2'(i);
            chk_en = 1'b1;
            wait_cyc(50);
            chk_en = 1'b0;
        end
        $display("test serial formats done");
        ramp = 1'b0;
        core_sample <= 16'sh1234;
        for (i = 1; i < 4; i++)
        begin
            if (i == 3)
                inv = 1'b1;
            wr(`ADCF_A_CTRL, inv ? 32'h0000_0009 : 32'h0000_0001);
            wr(`ADCF_A_FMT, 32'(i > 1 ? 1 : 2));
            wait_cyc(20);
            c0 = cap_count;
            wait_cyc(40);
            c0 = cap_count - c0;
            check(32'(c0 >= (i > 1 ? 19 : 9) && c0 <= (i > 1 ? 21 : 11)), 32'h1);
            check(32'(cap_word), 32'(fmt_of(16'sh1234, 2'h0)));
        end
        wr(`ADCF_A_FMT, 32'h0000_0000);
        wait_cyc(4);
        check(32'(data_clock_out), 32'h0);
        inv = 1'b0;
        $display("test divider done");
        wr(`ADCF_A_IMSK, 32'h0000_0002);
        wr(`ADCF_A_IST, 32'h0000_0007);
        wr(`ADCF_A_CTRL, 32'h0000_0003);
        wait_cyc(3);
        check(32'({data_oe, data_clock_oe, irq}), 32'h1);
        rdc(`ADCF_A_STAT, 32'h0000_0002);
        check(32'(rd[1:0]), 32'h2);
        wr(`ADCF_A_IMSK, 32'h0000_0000);
        check(32'(irq), 32'h0);
        wr(`ADCF_A_CTRL, 32'h0000_0001);
        wait_oe(n_down);
        wr(`ADCF_A_CTRL, 32'h0000_0005);
        wait_cyc(3);
        ahb(1'b0, `ADCF_A_STAT, 32'h0000_0000);
        check(32'({rd[1:0], data_oe}), 32'h2);
        wr(`ADCF_A_CTRL, 32'h0000_0001);
        wait_oe(n_stby);
        check(32'(n_stby < n_down), 32'h1);
        $display("test serial power done");
        wr(`ADCF_A_IMSK, 32'h0000_0001);
        core_sample <= -16'sd5;
        wait_cyc(20);
        check(32'({irq, overrange_o, data_o}), 32'h0000_c000);
        core_sample <= 16'sh1234;
        wait_cyc(20);
        wr(`ADCF_A_IST, 32'h0000_0001);
        check(32'(irq), 32'h0);
        $display("test interrupt done");
        wr(`ADCF_A_MODE, 32'h0000_0060);
        mode_pin <= 1'b1;
        wait_cyc(8);
        check(32'({data_oe, data_clock_oe}), 32'h0);
        mode_pin <= 1'b0;
        wait_cyc(8);
        check(32'({data_oe, data_clock_oe}), 32'h3);
        wr(`ADCF_A_MODE, 32'h0000_0020);
        mode_pin <= 1'b1;
        wait_cyc(8);
        ahb(1'b0, `ADCF_A_STAT, 32'h0000_0000);
        check(32'({rd[1:0], data_oe}), 32'h4);
        mode_pin <= 1'b0;
        wait_oe(n_down);
        wr(`ADCF_A_MODE, 32'h0000_0040);
        mode_pin <= 1'b1;
        wait_cyc(8);
        ahb(1'b0, `ADCF_A_STAT, 32'h0000_0000);
        check(32'({rd[1:0], data_oe}), 32'h2);
        mode_pin <= 1'b0;
        wait_oe(n_stby);
        wr(`ADCF_A_MODE, 32'h0000_0000);
        wr(`ADCF_A_CTRL, 32'h0000_0000);
        power_down_pin <= 1'b1;
        wait_cyc(8);
        check(32'({data_oe, data_clock_oe}), 32'h0);
        power_down_pin <= 1'b0;
        wait_oe(n_down);
        $display("test mode pin done");
        do_reset(1'b1);
        rdc(`ADCF_A_STAT, 32'h0000_0004);
        check(32'(rd[2]), 32'h1);
        ramp = 1'b1;
        exp_fmt = `ADCF_FMT_TC;
        chk_en = 1'b1;
        wait_cyc(60);
        chk_en = 1'b0;
        $display("test twos strap done");
        stop_test();
    end
endmodule : adcfmt_top_bench
